//--- logic/aswc_top.sv
// converter start control, busy tracking and window compare with axi4-lite registers
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/100ps
module aswc_top (
	input wire logic clk, // system clock, 20 mhz
	input wire logic rst, // synchronous reset, high
	input wire logic [aswc_pkg::AXI_ADDR_W-1:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [aswc_pkg::AXI_DATA_W-1:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [aswc_pkg::AXI_ADDR_W-1:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [aswc_pkg::AXI_DATA_W-1:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic timer0_ovf, // timer 0 overflow pulse
	input wire logic timer1_ovf, // timer 1 overflow pulse
	input wire logic timer2_ovf, // timer 2 overflow pulse
	input wire logic timer3_ovf, // timer 3 overflow pulse
	input wire logic ext_convert_strobe, // external convert strobe pin
	input wire logic conv_done_in, // converter finished, one-cycle pulse
	input wire logic [aswc_pkg::RES_W-1:0] conv_data, // converter result, valid with done
	output logic conv_start, // start pulse to the converter
	output logic conv_enable, // converter enable level
	output logic conv_track_delayed, // delayed track mode level
	output logic irq // interrupt request, level
);
	import aswc_pkg::*;

	// bus side strobes
	logic wr_en;
	logic [AXI_ADDR_W-1:0] wr_addr;
	logic [7:0] wr_data;
	logic wr_hit;
	logic [AXI_ADDR_W-1:0] rd_addr;
	logic [7:0] rd_data;
	logic rd_hit;

	// register state
	logic [7:0] gt_low_q;
	logic [7:0] gt_high_q;
	logic [7:0] lt_low_q;
	logic [7:0] lt_high_q;
	logic enable_q;
	logic track_q;
	aswc_src_type src_sel_q;
	logic busy_q;
	logic done_flag_q;
	logic win_flag_q;
	logic left_just_q;
	logic [1:0] irq_mask_q;
	logic [RES_W-1:0] result_q;
	logic eval_q;

	// pin synchroniser and edge detect
	logic strobe_meta_q;
	logic strobe_sync_q;
	logic strobe_prev_q;
	logic strobe_rise;

	// output flops
	logic conv_start_q;
	logic irq_q;

	// address decode
	logic [9:0] wr_idx_full;
	logic [9:0] rd_idx_full;
	logic wr_aligned;
	logic rd_aligned;
	logic [7:0] wr_idx;
	logic [7:0] rd_idx;
	logic we_gt_low;
	logic we_gt_high;
	logic we_lt_low;
	logic we_lt_high;
	logic we_control;
	logic we_config;
	logic we_status;
	logic we_mask;

	// derived values
	logic [7:0] control_rd;
	logic [1:0] irq_status;
	logic [7:0] result_high_rd;
	logic [7:0] result_low_rd;
	logic [15:0] result_word;
	logic [15:0] gt_word;
	logic [15:0] lt_word;
	logic win_match;
	logic sw_start;
	logic [7:0] src_vec;
	logic start_req;
	logic start_go;
	logic done_clear;
	logic win_clear;

	aswc_axil_slave u_bus (
		.clk(clk),
		.rst(rst),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_hit(wr_hit),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_hit(rd_hit)
	);

	// byte address to register index, only aligned words decode
	// index bits 9:8 must be zero
	assign wr_idx_full = wr_addr[AXI_ADDR_W-1:2];
	assign rd_idx_full = rd_addr[AXI_ADDR_W-1:2];
	assign wr_aligned = (wr_addr[1:0] == 2'h0) && (wr_idx_full[9:8] == 2'h0);
	assign rd_aligned = (rd_addr[1:0] == 2'h0) && (rd_idx_full[9:8] == 2'h0);
	assign wr_idx = wr_idx_full[7:0];
	assign rd_idx = rd_idx_full[7:0];

	// write enables per register
	// lands at the edge raising bvalid
	assign we_gt_low = wr_en && wr_aligned && (wr_idx == IDX_GT_LOW);
	assign we_gt_high = wr_en && wr_aligned && (wr_idx == IDX_GT_HIGH);
	assign we_lt_low = wr_en && wr_aligned && (wr_idx == IDX_LT_LOW);
	assign we_lt_high = wr_en && wr_aligned && (wr_idx == IDX_LT_HIGH);
	assign we_control = wr_en && wr_aligned && (wr_idx == IDX_CONTROL);
	assign we_config = wr_en && wr_aligned && (wr_idx == IDX_CONFIG);
	assign we_status = wr_en && wr_aligned && (wr_idx == IDX_IRQ_STATUS);
	assign we_mask = wr_en && wr_aligned && (wr_idx == IDX_IRQ_MASK);

	// result registers are read only, writes to them are accepted and dropped
	assign wr_hit = wr_aligned && (we_gt_low || we_gt_high || we_lt_low || we_lt_high || we_control
		|| we_config || we_status || we_mask || wr_idx == IDX_RESULT_HIGH || wr_idx == IDX_RESULT_LOW);

	// read view of control, status and result
	assign control_rd = {enable_q, track_q, done_flag_q, busy_q, win_flag_q, src_sel_q};
	assign irq_status = {win_flag_q, done_flag_q};
	assign result_high_rd = left_just_q ? result_q[9:2] : {6'h00, result_q[9:8]};
	assign result_low_rd = left_just_q ? {result_q[1:0], 6'h00} : result_q[7:0];

	// read multiplexer, unmapped reads return zero
	// latched at the address handshake
	assign rd_hit = rd_aligned && (rd_idx == IDX_GT_LOW || rd_idx == IDX_GT_HIGH || rd_idx == IDX_LT_LOW
		|| rd_idx == IDX_LT_HIGH || rd_idx == IDX_CONTROL || rd_idx == IDX_RESULT_HIGH
		|| rd_idx == IDX_RESULT_LOW || rd_idx == IDX_CONFIG || rd_idx == IDX_IRQ_STATUS
		|| rd_idx == IDX_IRQ_MASK);
	assign rd_data = !rd_aligned ? 8'h00 :
		(rd_idx == IDX_GT_LOW) ? gt_low_q :
		(rd_idx == IDX_GT_HIGH) ? gt_high_q :
		(rd_idx == IDX_LT_LOW) ? lt_low_q :
		(rd_idx == IDX_LT_HIGH) ? lt_high_q :
		(rd_idx == IDX_CONTROL) ? control_rd :
		(rd_idx == IDX_RESULT_HIGH) ? result_high_rd :
		(rd_idx == IDX_RESULT_LOW) ? result_low_rd :
		(rd_idx == IDX_CONFIG) ? {7'h00, left_just_q} :
		(rd_idx == IDX_IRQ_STATUS) ? {6'h00, irq_status} :
		(rd_idx == IDX_IRQ_MASK) ? {6'h00, irq_mask_q} : 8'h00;

	// limit byte registers
	// less-than low byte resets to zero
	always_ff @(posedge clk) begin
		if (rst) begin
			gt_low_q <= RST_GT_BYTE;
			gt_high_q <= RST_GT_BYTE;
			lt_low_q <= RST_LT_BYTE;
			lt_high_q <= RST_LT_BYTE;
		end else begin
			if (we_gt_low)
				gt_low_q <= wr_data;
			if (we_gt_high)
				gt_high_q <= wr_data;
			if (we_lt_low)
				lt_low_q <= wr_data;
			if (we_lt_high)
				lt_high_q <= wr_data;
		end
	end

	// plain control fields, configuration and mask
	// enable and track only stored
	always_ff @(posedge clk) begin
		if (rst) begin
			enable_q <= RST_CONTROL[CTL_ENABLE];
			track_q <= RST_CONTROL[CTL_TRACK];
			src_sel_q <= SRC_SOFTWARE;
			left_just_q <= RST_CONFIG[CFG_LEFT_JUST];
			irq_mask_q <= RST_IRQ_MASK;
		end else begin
			if (we_control) begin
				enable_q <= wr_data[CTL_ENABLE];
				track_q <= wr_data[CTL_TRACK];
				src_sel_q <= aswc_src_type'(wr_data[CTL_SEL_LSB +: 3]);
			end
			if (we_config)
				left_just_q <= wr_data[CFG_LEFT_JUST];
			if (we_mask)
				irq_mask_q <= wr_data[1:0];
		end
	end

	// external strobe: two flops, then rising edge detect
	// edge flop resets to the idle level
	// only the second flop feeds logic
	always_ff @(posedge clk) begin
		if (rst) begin
			strobe_meta_q <= 1'b0;
			strobe_sync_q <= 1'b0;
			strobe_prev_q <= 1'b0;
		end else begin
			strobe_meta_q <= ext_convert_strobe;
			strobe_sync_q <= strobe_meta_q;
			strobe_prev_q <= strobe_sync_q;
		end
	end

	// one-cycle pulse per rising edge
	assign strobe_rise = strobe_sync_q && !strobe_prev_q;

	// software start uses the source field carried by the same write
	assign sw_start = we_control && wr_data[CTL_BUSY] && (wr_data[CTL_SEL_LSB +: 3] == SRC_SOFTWARE);

	// start source selection, reserved codes never start
	// timer pulses need no sync
	assign src_vec = {1'b0, 1'b0, timer3_ovf, strobe_rise, timer1_ovf, timer2_ovf, timer0_ovf, 1'b0};
	assign start_req = sw_start || src_vec[src_sel_q];
	assign start_go = start_req && !busy_q;

	// busy follows the conversion from start to done
	// requests while busy are dropped
	always_ff @(posedge clk) begin
		if (rst) begin
			busy_q <= 1'b0;
			conv_start_q <= 1'b0;
		end else begin
			conv_start_q <= start_go;
			if (start_go)
				busy_q <= 1'b1;
			else if (conv_done_in)
				busy_q <= 1'b0;
		end
	end

	// capture each new result, then evaluate the window once on it
	// eval_q follows done by a cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			result_q <= '0;
			eval_q <= 1'b0;
		end else begin
			eval_q <= conv_done_in;
			if (conv_done_in)
				result_q <= conv_data;
		end
	end

	// result justified like the limits
	assign result_word = left_just_q ? {result_q, PAD_W'(0)} : {PAD_W'(0), result_q};
	assign gt_word = {gt_high_q, gt_low_q};
	assign lt_word = {lt_high_q, lt_low_q};

	aswc_window_cmp u_cmp (
		.result_word(result_word),
		.gt_limit(gt_word),
		.lt_limit(lt_word),
		.match(win_match)
	);

	// software clears: write 0 to the control bit or write 1 to the status bit
	assign done_clear = (we_control && !wr_data[CTL_DONE]) || (we_status && wr_data[IRQ_DONE]);
	assign win_clear = (we_control && !wr_data[CTL_WIN]) || (we_status && wr_data[IRQ_WIN]);

	// sticky flags, a set in the clearing cycle wins
	// so no event slips past a clear
	always_ff @(posedge clk) begin
		if (rst) begin
			done_flag_q <= 1'b0;
			win_flag_q <= 1'b0;
		end else begin
			if (conv_done_in)
				done_flag_q <= 1'b1;
			else if (done_clear)
				done_flag_q <= 1'b0;
			if (eval_q && win_match)
				win_flag_q <= 1'b1;
			else if (win_clear)
				win_flag_q <= 1'b0;
		end
	end

	// masked interrupt level
	// one cycle behind the flags
	always_ff @(posedge clk) begin
		if (rst)
			irq_q <= 1'b0;
		else
			irq_q <= |(irq_status & irq_mask_q);
	end

	// outputs straight from flops
	assign conv_start = conv_start_q;
	assign conv_enable = enable_q;
	assign conv_track_delayed = track_q;
	assign irq = irq_q;
endmodule : aswc_top

//--- logic/aswc_pkg.sv
// constants shared by the converter start and window compare block
package aswc_pkg;
	// axi4-lite geometry
	localparam int AXI_ADDR_W = 12;
	localparam int AXI_DATA_W = 32;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// register indices, byte address is four times the index
	localparam logic [7:0] IDX_GT_LOW = 8'hC3;
	localparam logic [7:0] IDX_GT_HIGH = 8'hC4;
	localparam logic [7:0] IDX_LT_LOW = 8'hC5;
	localparam logic [7:0] IDX_LT_HIGH = 8'hC6;
	localparam logic [7:0] IDX_CONTROL = 8'hE8;
	localparam logic [7:0] IDX_RESULT_HIGH = 8'hD0;
	localparam logic [7:0] IDX_RESULT_LOW = 8'hD1;
	localparam logic [7:0] IDX_CONFIG = 8'hD2;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'hD3;
	localparam logic [7:0] IDX_IRQ_MASK = 8'hD4;
	// reset values
	localparam logic [7:0] RST_GT_BYTE = 8'hFF;
	localparam logic [7:0] RST_LT_BYTE = 8'h00;
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_CONFIG = 8'h00;
	localparam logic [1:0] RST_IRQ_MASK = 2'h0;
	// control register fields
	localparam int CTL_ENABLE = 7;
	localparam int CTL_TRACK = 6;
	localparam int CTL_DONE = 5;
	localparam int CTL_BUSY = 4;
	localparam int CTL_WIN = 3;
	localparam int CTL_SEL_LSB = 0;
	// config, status and mask fields
	localparam int CFG_LEFT_JUST = 0;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_WIN = 1;
	// result geometry
	localparam int RES_W = 10;
	localparam int PAD_W = 6;
	// start source codes
	typedef enum logic [2:0] {
		SRC_SOFTWARE = 3'h0,
		SRC_TIMER0 = 3'h1,
		SRC_TIMER2 = 3'h2,
		SRC_TIMER1 = 3'h3,
		SRC_EXT_STROBE = 3'h4,
		SRC_TIMER3 = 3'h5,
		SRC_RESERVED6 = 3'h6,
		SRC_RESERVED7 = 3'h7
	} aswc_src_type;
endpackage : aswc_pkg

//--- logic/aswc_window_cmp.sv
// window comparator: result against greater-than and less-than limits
`timescale 1ns/100ps
module aswc_window_cmp (
	input wire logic [15:0] result_word, // formatted conversion result
	input wire logic [15:0] gt_limit, // greater-than limit word
	input wire logic [15:0] lt_limit, // less-than limit word
	output logic match // window condition met
);
	import aswc_pkg::*;
	// limit order alone chooses inside or outside window
	logic above_gt;
	logic below_lt;
	logic inside_mode;
	assign above_gt = result_word > gt_limit;
	assign below_lt = result_word < lt_limit;
	assign inside_mode = lt_limit > gt_limit;
	assign match = inside_mode ? (above_gt && below_lt) : (above_gt || below_lt);
endmodule : aswc_window_cmp

//--- logic/aswc_axil_slave.sv
// axi4-lite slave front end turning bus transfers into register strobes
`timescale 1ns/100ps
module aswc_axil_slave (
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset, high
	input wire logic [aswc_pkg::AXI_ADDR_W-1:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [aswc_pkg::AXI_DATA_W-1:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [aswc_pkg::AXI_ADDR_W-1:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [aswc_pkg::AXI_DATA_W-1:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	output logic wr_en, // one-cycle register write strobe
	output logic [aswc_pkg::AXI_ADDR_W-1:0] wr_addr, // write byte address
	output logic [7:0] wr_data, // low byte of write data
	input wire logic wr_hit, // write address is mapped
	output logic [aswc_pkg::AXI_ADDR_W-1:0] rd_addr, // read byte address
	input wire logic [7:0] rd_data, // register read value
	input wire logic rd_hit // read address is mapped
);
	import aswc_pkg::*;
	logic aw_full_q;
	logic w_full_q;
	logic [AXI_ADDR_W-1:0] awaddr_q;
	logic [7:0] wdata_q;
	logic wlane_q;
	logic aw_take;
	logic w_take;
	logic ar_take;
	// address and data are held until both have arrived
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take = s_axi_wvalid && s_axi_wready;
	assign ar_take = s_axi_arvalid && s_axi_arready;
	assign wr_en = aw_full_q && w_full_q && !s_axi_bvalid && wlane_q;
	assign wr_addr = awaddr_q;
	assign wr_data = wdata_q;
	assign rd_addr = s_axi_araddr;
	// write channel capture
	always_ff @(posedge clk) begin
		if (rst) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= 8'h00;
			wlane_q <= 1'b0;
		end else begin
			if (aw_take) begin
				aw_full_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (w_take) begin
				w_full_q <= 1'b1;
				wdata_q <= s_axi_wdata[7:0];
				wlane_q <= s_axi_wstrb[0];
			end
			if (aw_full_q && w_full_q && !s_axi_bvalid) begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
			end
		end
	end
	// write ready and response
	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (aw_take)
				s_axi_awready <= 1'b0;
			if (w_take)
				s_axi_wready <= 1'b0;
			if (aw_full_q && w_full_q && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end
	// read channel: data latched at the address handshake
	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (ar_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h00_0000, rd_data};
			s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule : aswc_axil_slave

//--- sim/aswc_top_chk.sv
// checker for bus handshakes and start pulses at the top module's ports
`timescale 1ns/100ps
module aswc_top_chk (
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset, high
	input wire logic s_axi_awvalid, // write address valid
	input wire logic s_axi_awready, // write address ready
	input wire logic [1:0] s_axi_bresp, // write response
	input wire logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [aswc_pkg::AXI_ADDR_W-1:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	input wire logic s_axi_arready, // read address ready
	input wire logic [aswc_pkg::AXI_DATA_W-1:0] s_axi_rdata, // read data
	input wire logic [1:0] s_axi_rresp, // read response
	input wire logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic conv_start, // start pulse
	input wire logic conv_done_in // converter finished
);
	import aswc_pkg::*;
	logic busy_q; // a conversion is outstanding at the ports
	logic busy_d;
	// busy as seen from the start and done pulses
	assign busy_d = conv_start ? 1'b1 : (conv_done_in ? 1'b0 : busy_q);
	always_ff @(posedge clk) begin
		busy_q <= rst ? 1'b0 : busy_d;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// handshakes taken on the address channels
	sequence s_aw_taken;
		s_axi_awvalid && s_axi_awready;
	endsequence
	sequence s_ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_start_one_cycle: assert property (conv_start |=> !conv_start)
		else $error("start pulse longer than one cycle");
	a_start_when_idle: assert property (conv_start |-> !busy_q)
		else $error("start issued during a conversion");
	a_write_answered: assert property (s_aw_taken |-> ##[1:30] s_axi_bvalid)
		else $error("write not answered");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_read_latency: assert property (s_ar_taken |=> s_axi_rvalid)
		else $error("read data late");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed while stalled");
	a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
		else $error("read data upper bits not zero");
	a_read_unmapped: assert property (s_ar_taken and (s_axi_araddr[11:10] != 2'h0) |=> s_axi_rresp == RESP_SLVERR)
		else $error("unmapped read not refused");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while answering");
	a_write_closes: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
		else $error("write not closed");
	a_read_closes: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
		else $error("read not closed");
endmodule : aswc_top_chk

bind aswc_top aswc_top_chk u_chk (.clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .conv_start, .conv_done_in);

//--- sim/aswc_conv_model.sv
// behavioural converter answering start pulses after a set latency
`timescale 1ns/100ps
module aswc_conv_model (
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset, high
	input wire logic conv_start, // start pulse from the block
	input wire logic [9:0] result, // value to return
	input wire logic [4:0] lat, // cycles from start to done, at least 1
	output logic conv_done_in, // one-cycle finish pulse
	output logic [9:0] conv_data // result, valid only with done
);
	logic [4:0] cnt_q; // cycles left in the conversion
	initial begin
		conv_done_in = 1'b0;
		conv_data = 10'h000;
		cnt_q = 5'h00;
	end
	// data outside the done cycle flips every cycle so a late sample shows garbage
	always @(posedge clk) begin
		conv_done_in <= 1'b0;
		conv_data <= ~conv_data;
		if (rst) begin
			cnt_q <= 5'h00;
		end else if (conv_start) begin
			cnt_q <= lat;
		end else if (cnt_q == 5'h01) begin
			conv_done_in <= 1'b1;
			conv_data <= result;
			cnt_q <= 5'h00;
		end else if (cnt_q != 5'h00) begin
			cnt_q <= cnt_q - 5'h01;
		end
	end
endmodule : aswc_conv_model

//--- sim/aswc_top_bench.sv
// self-checking bench for the converter start and window compare block
`timescale 1ns/100ps
module aswc_top_bench;
	import aswc_pkg::*;
	logic clk = 1'b0, rst = 1'b1;
	logic [AXI_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [AXI_DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata, rd_val;
	logic [3:0] s_axi_wstrb = 4'hF, tmr = 4'h0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, conv_start, conv_done_in;
	logic [1:0] s_axi_bresp, s_axi_rresp, wr_resp, rd_resp;
	logic ext_convert_strobe = 0, en_pin, trk_pin;
	logic [9:0] conv_data, mres = 10'h000;
	logic [4:0] mlat = 5'h03;
	int n_mismatch = 0, num_checks = 0, n_start = 0, s0;
	localparam logic [15:0] GTV [3] = '{16'h0040, 16'h0080, 16'h1000};
	localparam logic [15:0] LTV [3] = '{16'h0080, 16'h0040, 16'h2000};
	localparam logic [9:0] RV [10] = '{10'h040, 10'h041, 10'h07F, 10'h080, 10'h03F, 10'h040, 10'h080,
		10'h081, 10'h041, 10'h03F};
	localparam int MP [8] = '{6, 0, 2, 1, 4, 3, 6, 6}; // trigger that each source code listens to
	aswc_top uut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer0_ovf(tmr[0]),
		.timer1_ovf(tmr[1]), .timer2_ovf(tmr[2]), .timer3_ovf(tmr[3]), .ext_convert_strobe, .conv_done_in,
		.conv_data, .conv_start, .conv_enable(en_pin), .conv_track_delayed(trk_pin), .irq);
	aswc_conv_model u_model (.clk, .rst, .conv_start, .result(mres), .lat(mlat), .conv_done_in, .conv_data);
	// clock and start pulse counter
	initial forever #25 clk = ~clk;
	always @(negedge clk) if (conv_start === 1'b1) n_start++;
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : close_out
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	function automatic logic [11:0] ra(input logic [7:0] idx);
		return {2'h0, idx, 2'h0};
	endfunction : ra
	// write: address, data and bready raised together, each dropped at the edge that takes it
	task automatic axw(input logic [11:0] ad, input logic [7:0] d);
		logic a, w, b;
		int i;
		b = 0;
		@(posedge clk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		for (i = 0; i < 50 && !b; i++) begin
			@(negedge clk);
			a = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid && s_axi_bready;
			wr_resp = s_axi_bresp;
			@(posedge clk);
			if (a) s_axi_awvalid <= 0;
			if (w) s_axi_wvalid <= 0;
			if (b) s_axi_bready <= 0;
		end
		if (!b) begin
			chk("write timeout", 0, 1);
			close_out();
		end
	endtask : axw
	// read: address and rready raised together, rready held until data is taken
	task automatic axr(input logic [11:0] ad);
		logic a, r;
		int i;
		r = 0;
		@(posedge clk);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (i = 0; i < 50 && !r; i++) begin
			@(negedge clk);
			a = s_axi_arvalid && s_axi_arready;
			r = s_axi_rvalid && s_axi_rready;
			rd_val = s_axi_rdata;
			rd_resp = s_axi_rresp;
			@(posedge clk);
			if (a) s_axi_arvalid <= 0;
			if (r) s_axi_rready <= 0;
		end
		if (!r) begin
			chk("read timeout", 0, 1);
			close_out();
		end
	endtask : axr
	// one start request: timers 0 to 3, strobe edge, or a software busy write
	task automatic trig(input int k, input logic [2:0] code);
		@(posedge clk);
		if (k < 4) begin
			tmr[k] <= 1;
			@(posedge clk);
			tmr <= 4'h0;
		end else if (k == 4) begin
			ext_convert_strobe <= 1;
			repeat (4) @(posedge clk);
			ext_convert_strobe <= 0;
		end else axw(ra(IDX_CONTROL), 8'h10 | {5'h00, code});
		repeat (12) @(posedge clk);
	endtask : trig
	task automatic chk_irq(input logic exp);
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("irq", irq, exp);
	endtask : chk_irq
	function automatic logic wexp(input logic [15:0] gt, lt, input logic lj, input logic [9:0] r);
		logic [15:0] w;
		w = lj ? {r, 6'h00} : {6'h00, r};
		return (lt > gt) ? (w > gt && w < lt) : (w < lt || w > gt);
	endfunction : wexp
	initial begin
		repeat (3) @(posedge clk);
		rst <= 0;
		// reset values, read-write limit and unmapped places
		axr(ra(IDX_GT_LOW)); chk("gt low reset", rd_val, 32'(RST_GT_BYTE));
		axr(ra(IDX_GT_HIGH)); chk("gt high reset", rd_val, 32'h0000_00FF);
		axr(ra(IDX_LT_HIGH)); chk("lt high reset", rd_val, 32'h0000_0000);
		axr(ra(IDX_CONTROL)); chk("control reset", rd_val, 32'h0000_0000);
		axw(ra(IDX_CONTROL), 8'hC0); @(negedge clk); chk("enable pins", {en_pin, trk_pin}, 2'h3);
		axw(ra(IDX_GT_LOW), 8'h5A); axr(ra(IDX_GT_LOW)); chk("gt low rw", rd_val, 32'h0000_005A);
		axr(12'h400); chk("unmapped read", {rd_resp, rd_val[29:0]}, {RESP_SLVERR, 30'h0});
		axw(12'h400, 8'h01); chk("unmapped write", wr_resp, RESP_SLVERR);
		$display("test reset done");
		// busy during a slow conversion, a second start is ignored
		mlat <= 5'h14;
		s0 = n_start;
		axw(ra(IDX_CONTROL), 8'h10);
		axr(ra(IDX_CONTROL)); chk("busy high", rd_val[CTL_BUSY], 1);
		axw(ra(IDX_CONTROL), 8'h10);
		repeat (30) @(posedge clk);
		chk("starts while busy", n_start - s0, 1);
		axr(ra(IDX_CONTROL)); chk("busy low, done", rd_val[5:4], 2'h2);
		mlat <= 5'h03;
		$display("test busy done");
		// every source code against every trigger kind
		for (int c = 0; c < 8; c++) begin
			axw(ra(IDX_CONTROL), 8'(c));
			for (int k = 0; k < 6; k++) begin
				s0 = n_start;
				trig(k, 3'(c));
				chk("start count", n_start - s0, (k == 5) ? (c == 0) : (MP[c] == k));
			end
		end
		$display("test sources done");
		// window cases: inside, outside, left justified
		for (int i = 0; i < 10; i++) begin
			if (i % 4 == 0) begin
				axw(ra(IDX_GT_HIGH), GTV[i / 4][15:8]);
				axw(ra(IDX_GT_LOW), GTV[i / 4][7:0]);
				axw(ra(IDX_LT_HIGH), LTV[i / 4][15:8]);
				axw(ra(IDX_LT_LOW), LTV[i / 4][7:0]);
				axw(ra(IDX_CONFIG), 8'(i / 8));
			end
			@(posedge clk);
			mres <= RV[i];
			axw(ra(IDX_CONTROL), 8'h10);
			repeat (10) @(posedge clk);
			axr(ra(IDX_CONTROL));
			chk("window flag", rd_val[CTL_WIN], wexp(GTV[i / 4], LTV[i / 4], i >= 8, RV[i]));
		end
		axr(ra(IDX_LT_HIGH)); chk("lt high rw", rd_val, 32'h0000_0020);
		axr(ra(IDX_RESULT_HIGH)); chk("result high", rd_val, 32'(RV[9][9:2]));
		axr(ra(IDX_RESULT_LOW)); chk("result low", rd_val, {24'h00_0000, RV[9][1:0], 6'h00});
		$display("test window done");
		// interrupt raised, kept sticky, cleared, masked
		axw(ra(IDX_IRQ_STATUS), 8'h03);
		axw(ra(IDX_IRQ_MASK), 8'h02);
		axw(ra(IDX_CONTROL), 8'h01);
		@(posedge clk); mres <= 10'h041;
		trig(0, 3'h1); chk_irq(1);
		@(posedge clk); mres <= 10'h03F;
		trig(0, 3'h1);
		axr(ra(IDX_CONTROL)); chk("window sticky", rd_val[CTL_WIN], 1);
		axw(ra(IDX_IRQ_STATUS), 8'h02); chk_irq(0);
		axw(ra(IDX_IRQ_MASK), 8'h00);
		@(posedge clk); mres <= 10'h041;
		trig(0, 3'h1); chk_irq(0);
		axw(ra(IDX_IRQ_MASK), 8'h02); chk_irq(1);
		axw(ra(IDX_IRQ_STATUS), 8'h02); chk_irq(0);
		$display("test interrupt done");
		close_out();
	end
endmodule : aswc_top_bench
